// ===== src/hsf_pkg.sv
package hsf_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] STATUS_OFFSET = 12'h000;
    localparam logic [11:0] CONTROL_OFFSET = 12'h004;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] STICKY_MASK = 32'hED41_AD90;
    localparam logic [31:0] CONTROL_MASK = 32'h0000_01FF;

    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int RX_REMAIN_LSB = 0;
    localparam int TX_FRAME_COMPLETE = 4;
    localparam int TX_FIFO_SPACE = 5;
    localparam int CTS_LEVEL = 6;
    localparam int CTS_CHANGE = 7;
    localparam int TX_UNDERRUN = 8;
    localparam int RX_FIFO_DATA = 9;
    localparam int TX_FRAME_OK = 10;
    localparam int RX_FLAG_SEEN = 11;
    localparam int DCD_LEVEL = 12;
    localparam int DCD_CHANGE = 13;
    localparam int RX_FRAME_VALID = 14;
    localparam int RX_IDLE_LINE = 15;
    localparam int RX_ABORT = 16;
    localparam int RX_CRC_ERROR = 17;
    localparam int RX_NONOCTET = 18;
    localparam int RX_OVERRUN = 19;
    localparam int DMA_TX_ABORT = 22;
    localparam int RX_CLOCK_ERROR = 23;
    localparam int DMA_RX_FRAME_DONE = 24;
    localparam int DMA_RX_NOT_OWNED = 26;
    localparam int DMA_TX_FRAME_DONE = 27;
    localparam int DMA_TX_NOT_OWNED = 29;
    localparam int DPLL_ONE_MISS = 30;
    localparam int DPLL_TWO_MISS = 31;

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int CTL_DMA_TX_ENABLE = 0;
    localparam int CTL_DMA_RX_ENABLE = 1;
    localparam int CTL_TX_FOUR_WORD = 2;
    localparam int CTL_RX_FOUR_WORD = 3;
    localparam int CTL_TX_STOP_SKIP = 4;
    localparam int CTL_RX_STOP_SKIP = 5;
    localparam int CTL_MULTI_FRAME = 6;
    localparam int CTL_DPLL_ENABLE = 7;
    localparam int CTL_FM_MODE = 8;

    // ------------------------------------------------------------
    // receive line counts
    // ------------------------------------------------------------
    localparam logic [3:0] ABORT_ONES = 4'h7;
    localparam logic [3:0] IDLE_ONES = 4'hF;
    localparam logic [7:0] FLAG_PATTERN = 8'h7E;
    localparam logic [1:0] DPLL_MISS_LIMIT = 2'h2;
endpackage : hsf_pkg

// ===== src/hsf_status_flags.sv
// Behaviour
// [RULE1] on frame end report valid bytes minus one: 0-3 one-word, 0-15 four-word
// [RULE2] tx complete flag sets when queue empty and abort or closing flag sent
// [RULE3] tx space flag follows first one/four queue registers empty; low in DMA tx
// [RULE4] cts and dcd level flags are inverted pin levels, no interrupt
// [RULE5] cts change flag sets on each clear_to_send_n transition; write one clears
// [RULE6] underrun mid-frame requests an abort and sets the underrun flag
// [RULE7] rx data flag follows last one/four registers or end marker; low in DMA rx
// [RULE8] tx frame ok flag sets when a frame is sent successfully
// [RULE9] rx flag seen sets on final bit of a received flag; write one clears
// [RULE10] dcd change flag sets on each carrier_detect_n transition; write one clears
// [RULE11] rx frame valid shows error-free frame end in final queue location
// [RULE12] idle flag sets after 15 ones, holds until a zero; write one clears
// [RULE13] abort flag sets on seven or more ones; write one clears
// [RULE14] crc error and non-octet flags show the completed frame's errors
// [RULE15] overrun flag shows data pushed into a full receive queue
// [RULE16] DMA tx abort on underrun or cts loss sets flag, clears DMA tx enable
// [RULE17] rx clock error flag shows an unstable receive clock
// [RULE18] DMA rx frame done sets when last byte reaches memory; write one clears
// [RULE19] not-owned with select set sets flag and disables that DMA direction
// [RULE20] DMA tx frame done only without multi-frame; multi-frame keeps sending
// [RULE21] DPLL one miss, then two misses plus search; two-miss zero otherwise
// [RULE22] latched bits are write-one-to-clear, zero writes leave them
// [RULE23] reading the status word changes nothing
// [RULE24] status word resets to zero
//
// Our own choices: the APB register port and the address map.
module hsf_status_flags (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // modem pins
    input wire logic clear_to_send_n,
    input wire logic carrier_detect_n,
    // transmitter and tx queue
    input wire logic txQueueEmpty,
    input wire logic txFirstRegEmpty,
    input wire logic txFirstFourEmpty,
    input wire logic txAbortSent,
    input wire logic txClosingFlagSent,
    input wire logic txUnderrun,
    input wire logic txFrameSentOk,
    // receiver bit stream and rx queue
    input wire logic rxBitValid,
    input wire logic rxBit,
    input wire logic rxLastRegFull,
    input wire logic rxLastFourFull,
    input wire logic rxEndMarker,
    input wire logic [3:0] rxLastByteCount,
    input wire logic rxFrameGood,
    input wire logic rxCrcBad,
    input wire logic rxNonOctet,
    input wire logic rxOverrun,
    input wire logic rxClockUnstable,
    // dma engines
    input wire logic dmaRxFrameWritten,
    input wire logic dmaRxNotOwned,
    input wire logic dmaTxNotOwned,
    input wire logic dmaTxFrameSent,
    // dpll
    input wire logic dpllMissedEdge,
    input wire logic dpllEdgeFound,
    // control outputs
    output logic dmaTxEnable,
    output logic dmaRxEnable,
    output logic multiFrame,
    output logic dpllEnable,
    output logic txAbortRequest,
    output logic dpllSearchRequest
);
    logic [31:0] controlWord;
    logic [31:0] stickyFlags;
    logic [31:0] setVec;
    logic [31:0] clrVec;
    logic [31:0] liveVec;
    logic [31:0] statusWord;
    logic ctsSync1;
    logic ctsSync2;
    logic ctsPrev;
    logic dcdSync1;
    logic dcdSync2;
    logic dcdPrev;
    logic ctsToggle;
    logic dcdToggle;
    logic ctsLost;
    logic [7:0] rxShift;
    logic [7:0] next_rxShift;
    logic [3:0] onesCount;
    logic [3:0] next_onesCount;
    logic [1:0] missCount;
    logic dpllActive;
    logic dmaTxAbortEvent;
    logic txNotOwnedEvent;
    logic rxNotOwnedEvent;
    logic dpllSecondMiss;
    logic [3:0] rxRemaining;
    logic accessPhase;
    logic statusHit;
    logic controlHit;
    logic statusWrite;
    logic controlWrite;

    assign accessPhase = psel && penable && pready;
    assign statusHit = (paddr == hsf_pkg::STATUS_OFFSET);
    assign controlHit = (paddr == hsf_pkg::CONTROL_OFFSET);
    assign statusWrite = accessPhase && pwrite && statusHit && clkEn;
    assign controlWrite = accessPhase && pwrite && controlHit && clkEn;

    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctsSync1 <= 1'b1;
            ctsSync2 <= 1'b1;
            ctsPrev <= 1'b1;
            dcdSync1 <= 1'b1;
            dcdSync2 <= 1'b1;
            dcdPrev <= 1'b1;
        end
        else if (clkEn)
        begin
            ctsSync1 <= clear_to_send_n;
            ctsSync2 <= ctsSync1;
            ctsPrev <= ctsSync2;
            dcdSync1 <= carrier_detect_n;
            dcdSync2 <= dcdSync1;
            dcdPrev <= dcdSync2;
        end
    end

    assign ctsToggle = ctsSync2 ^ ctsPrev; // [RULE5]
    assign dcdToggle = dcdSync2 ^ dcdPrev; // [RULE10]
    assign ctsLost = ctsSync2 && !ctsPrev;

    always_comb
    begin
        next_rxShift = {rxShift[6:0], rxBit};
        if (!rxBit)
        begin
            next_onesCount = 4'h0;
        end
        else if (onesCount == hsf_pkg::IDLE_ONES)
        begin
            next_onesCount = onesCount;
        end
        else
        begin
            next_onesCount = onesCount + 4'h1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxShift <= 8'h00;
            onesCount <= 4'h0;
        end
        else if (clkEn && rxBitValid)
        begin
            rxShift <= next_rxShift;
            onesCount <= next_onesCount;
        end
    end

    assign dpllActive = controlWord[hsf_pkg::CTL_DPLL_ENABLE]
        && controlWord[hsf_pkg::CTL_FM_MODE];
    assign dpllSecondMiss = dpllActive && dpllMissedEdge
        && (missCount == hsf_pkg::DPLL_MISS_LIMIT - 2'h1);

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            missCount <= 2'h0;
        end
        else if (clkEn)
        begin
            if (!dpllActive || dpllEdgeFound || dpllSecondMiss)
            begin
                missCount <= 2'h0;
            end
            else if (dpllMissedEdge)
            begin
                missCount <= missCount + 2'h1; // [RULE21]
            end
        end
    end

    assign dmaTxAbortEvent = dmaTxEnable && (txUnderrun || ctsLost);
    assign txNotOwnedEvent = dmaTxNotOwned && controlWord[hsf_pkg::CTL_TX_STOP_SKIP];
    assign rxNotOwnedEvent = dmaRxNotOwned && controlWord[hsf_pkg::CTL_RX_STOP_SKIP];

    always_comb
    begin
        setVec = 32'h0000_0000;
        setVec[hsf_pkg::TX_FRAME_COMPLETE] = txQueueEmpty
            && (txAbortSent || txClosingFlagSent); // [RULE2]
        setVec[hsf_pkg::CTS_CHANGE] = ctsToggle; // [RULE5]
        setVec[hsf_pkg::TX_UNDERRUN] = txUnderrun; // [RULE6]
        setVec[hsf_pkg::TX_FRAME_OK] = txFrameSentOk; // [RULE8]
        setVec[hsf_pkg::RX_FLAG_SEEN] = rxBitValid
            && (next_rxShift == hsf_pkg::FLAG_PATTERN); // [RULE9]
        setVec[hsf_pkg::DCD_CHANGE] = dcdToggle; // [RULE10]
        setVec[hsf_pkg::RX_IDLE_LINE] = (onesCount == hsf_pkg::IDLE_ONES); // [RULE12]
        setVec[hsf_pkg::RX_ABORT] = rxBitValid
            && (next_onesCount == hsf_pkg::ABORT_ONES); // [RULE13]
        setVec[hsf_pkg::DMA_TX_ABORT] = dmaTxAbortEvent; // [RULE16]
        setVec[hsf_pkg::DMA_RX_FRAME_DONE] = dmaRxFrameWritten; // [RULE18]
        setVec[hsf_pkg::DMA_RX_NOT_OWNED] = rxNotOwnedEvent; // [RULE19]
        setVec[hsf_pkg::DMA_TX_NOT_OWNED] = txNotOwnedEvent; // [RULE19]
        setVec[hsf_pkg::DMA_TX_FRAME_DONE] = dmaTxFrameSent
            && !controlWord[hsf_pkg::CTL_MULTI_FRAME]; // [RULE20]
        setVec[hsf_pkg::DPLL_ONE_MISS] = dpllActive && dpllMissedEdge
            && (missCount == 2'h0); // [RULE21]
        setVec[hsf_pkg::DPLL_TWO_MISS] = dpllSecondMiss; // [RULE21]
    end

    always_comb
    begin
        clrVec = statusWrite ? (pwdata & hsf_pkg::STICKY_MASK) : 32'h0000_0000; // [RULE22]
        if (!dpllActive)
        begin
            clrVec[hsf_pkg::DPLL_TWO_MISS] = 1'b1; // [RULE21]
        end
    end

    // ------------------------------------------------------------
    // sticky flags, set wins over clear
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_sticky
            if (hsf_pkg::STICKY_MASK[gi])
            begin : g_flop
                always_ff @(posedge mclk or posedge sys_rst)
                begin
                    if (sys_rst)
                    begin
                        stickyFlags[gi] <= hsf_pkg::STATUS_RESET[gi]; // [RULE24]
                    end
                    else if (clkEn)
                    begin
                        stickyFlags[gi] <= setVec[gi] || (stickyFlags[gi] && !clrVec[gi]); // [RULE22]
                    end
                end
            end
            else
            begin : g_none
                assign stickyFlags[gi] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // live condition bits
    // ------------------------------------------------------------
    always_comb
    begin
        if (!rxEndMarker)
        begin
            rxRemaining = 4'h0;
        end
        else if (controlWord[hsf_pkg::CTL_RX_FOUR_WORD])
        begin
            rxRemaining = rxLastByteCount; // [RULE1]
        end
        else
        begin
            rxRemaining = {2'b00, rxLastByteCount[1:0]}; // [RULE1]
        end
    end

    always_comb
    begin
        liveVec = 32'h0000_0000;
        liveVec[hsf_pkg::RX_REMAIN_LSB +: 4] = rxRemaining; // [RULE1]
        liveVec[hsf_pkg::TX_FIFO_SPACE] = !dmaTxEnable
            && (controlWord[hsf_pkg::CTL_TX_FOUR_WORD] ? txFirstFourEmpty
                : txFirstRegEmpty); // [RULE3]
        liveVec[hsf_pkg::CTS_LEVEL] = !ctsSync2; // [RULE4]
        liveVec[hsf_pkg::DCD_LEVEL] = !dcdSync2; // [RULE4]
        liveVec[hsf_pkg::RX_FIFO_DATA] = !dmaRxEnable && (rxEndMarker
            || (controlWord[hsf_pkg::CTL_RX_FOUR_WORD] ? rxLastFourFull
                : rxLastRegFull)); // [RULE7]
        liveVec[hsf_pkg::RX_FRAME_VALID] = rxEndMarker && rxFrameGood; // [RULE11]
        liveVec[hsf_pkg::RX_CRC_ERROR] = rxEndMarker && rxCrcBad; // [RULE14]
        liveVec[hsf_pkg::RX_NONOCTET] = rxEndMarker && rxNonOctet; // [RULE14]
        liveVec[hsf_pkg::RX_OVERRUN] = rxOverrun; // [RULE15]
        liveVec[hsf_pkg::RX_CLOCK_ERROR] = rxClockUnstable; // [RULE17]
    end

    assign statusWord = stickyFlags | liveVec;

    // ------------------------------------------------------------
    // control register and dma enables
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            controlWord <= hsf_pkg::CONTROL_RESET;
        end
        else if (clkEn)
        begin
            if (controlWrite)
            begin
                controlWord <= pwdata & hsf_pkg::CONTROL_MASK;
            end
            if (dmaTxAbortEvent || txNotOwnedEvent)
            begin
                controlWord[hsf_pkg::CTL_DMA_TX_ENABLE] <= 1'b0; // [RULE16]
            end
            if (rxNotOwnedEvent)
            begin
                controlWord[hsf_pkg::CTL_DMA_RX_ENABLE] <= 1'b0; // [RULE19]
            end
        end
    end

    assign dmaTxEnable = controlWord[hsf_pkg::CTL_DMA_TX_ENABLE];
    assign dmaRxEnable = controlWord[hsf_pkg::CTL_DMA_RX_ENABLE];
    assign multiFrame = controlWord[hsf_pkg::CTL_MULTI_FRAME]; // [RULE20]
    assign dpllEnable = controlWord[hsf_pkg::CTL_DPLL_ENABLE];

    // ------------------------------------------------------------
    // request pulses to transmitter and dpll
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            txAbortRequest <= 1'b0;
            dpllSearchRequest <= 1'b0;
        end
        else if (clkEn)
        begin
            txAbortRequest <= txUnderrun || dmaTxAbortEvent; // [RULE6]
            dpllSearchRequest <= dpllSecondMiss; // [RULE21]
        end
    end

    // ------------------------------------------------------------
    // apb answer, reads have no side effect
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !statusHit && !controlHit;
            if (psel && !penable && !pwrite)
            begin
                if (statusHit)
                begin
                    prdata <= statusWord; // [RULE23]
                end
                else if (controlHit)
                begin
                    prdata <= controlWord;
                end
                else
                begin
                    prdata <= 32'h0000_0000;
                end
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule : hsf_status_flags

// ===== sim/hsf_status_props.sv
module hsf_status_props (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // pins and events
    input wire logic clear_to_send_n,
    input wire logic txUnderrun,
    input wire logic rxEndMarker,
    input wire logic dpllMissedEdge,
    // control outputs
    input wire logic dmaTxEnable,
    input wire logic dmaRxEnable,
    input wire logic dpllEnable,
    input wire logic txAbortRequest,
    input wire logic dpllSearchRequest
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    logic [4:0] ctsHist;
    logic [4:0] enHist;
    logic rdSt;
    assign rdSt = psel && penable && pready && !pwrite && paddr == hsf_pkg::STATUS_OFFSET;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctsHist <= 5'h1F;
            enHist <= 5'h00;
        end
        else
        begin
            ctsHist <= {ctsHist[3:0], clear_to_send_n};
            enHist <= {enHist[3:0], clkEn};
        end
    end
    chk_cts_level:
        assert property (rdSt && enHist == 5'h1F && ctsHist[4:1] inside {4'h0, 4'hF}
            |-> prdata[hsf_pkg::CTS_LEVEL] == !ctsHist[2])
        else $error("cts level bit does not follow pin");
    chk_underrun_abort:
        assert property (txUnderrun && clkEn |=> txAbortRequest)
        else $error("no abort request after underrun");
    chk_dma_abort_off:
        assert property (dmaTxEnable && txUnderrun && clkEn |=> !dmaTxEnable)
        else $error("dma tx enable kept after abort");
    chk_space_dma_low:
        assert property (rdSt && $past(dmaTxEnable) |-> !prdata[hsf_pkg::TX_FIFO_SPACE])
        else $error("tx space shown during dma tx");
    chk_rxdata_dma_low:
        assert property (rdSt && $past(dmaRxEnable) |-> !prdata[hsf_pkg::RX_FIFO_DATA])
        else $error("rx data shown during dma rx");
    chk_remain_idle:
        assert property (rdSt && !$past(rxEndMarker) |-> prdata[3:0] == 4'h0)
        else $error("remaining count without frame end");
    chk_search_cause:
        assert property ($rose(dpllSearchRequest) |-> $past(dpllMissedEdge) && $past(dpllEnable))
        else $error("search request without a miss");
    chk_two_miss_off:
        assert property (rdSt && !$past(dpllEnable) |-> !prdata[hsf_pkg::DPLL_TWO_MISS])
        else $error("two miss set with dpll off");
    cover property (rdSt && prdata[hsf_pkg::CTS_LEVEL]);
    cover property (txAbortRequest && !dmaTxEnable);
    cover property (dpllSearchRequest);
endmodule : hsf_status_props

bind hsf_status_flags hsf_status_props chk (
    .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .clear_to_send_n(clear_to_send_n), .txUnderrun(txUnderrun), .rxEndMarker(rxEndMarker),
    .dpllMissedEdge(dpllMissedEdge), .dmaTxEnable(dmaTxEnable), .dmaRxEnable(dmaRxEnable),
    .dpllEnable(dpllEnable), .txAbortRequest(txAbortRequest),
    .dpllSearchRequest(dpllSearchRequest)
);

// ===== sim/hsf_line_model.sv
module hsf_line_model (
    // clock
    input wire logic mclk,
    // modem pins and received line
    output logic clear_to_send_n,
    output logic carrier_detect_n,
    output logic rxBitValid,
    output logic rxBit
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {clear_to_send_n, carrier_detect_n} = 2'h3;
        {rxBitValid, rxBit} = 2'h0;
    end
    // msb first; line shows the inverse between bits
    task automatic send(input logic [7:0] bits, input int n, input int gap);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge mclk);
            rxBitValid <= 1'b1;
            rxBit <= bits[i];
            @(posedge mclk);
            rxBitValid <= 1'b0;
            rxBit <= ~bits[i];
            repeat (gap) @(posedge mclk);
        end
    endtask : send
    task automatic pin(input int which, input logic lvl);
        @(posedge mclk);
        if (which == 0)
            clear_to_send_n <= lvl;
        else
            carrier_detect_n <= lvl;
    endtask : pin
endmodule : hsf_line_model

// ===== sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ST = hsf_pkg::STATUS_OFFSET;
    localparam logic [11:0] CT = hsf_pkg::CONTROL_OFFSET;
    logic mclk, sys_rst, clkEn, psel, penable, pwrite, pready, pslverr, err;
    logic clear_to_send_n, carrier_detect_n, rxBitValid, rxBit;
    logic dmaTxEnable, dmaRxEnable, multiFrame, dpllEnable, txAbortRequest, dpllSearchRequest;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, expSt, w;
    logic [9:0] ev;
    logic [10:0] lv;
    logic [3:0] cnt;
    int errTotal = 0;
    int comparisons = 0;
    int seed = 32'hDFE3;
    int pi[6] = '{0, 1, 3, 4, 7, 2};
    int pb[6] = '{4, 4, 10, 24, 27, 8};
    hsf_status_flags DUT (
        .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clear_to_send_n(clear_to_send_n),
        .carrier_detect_n(carrier_detect_n), .txQueueEmpty(lv[0]), .txFirstRegEmpty(lv[1]),
        .txFirstFourEmpty(lv[2]), .txAbortSent(ev[0]), .txClosingFlagSent(ev[1]),
        .txUnderrun(ev[2]), .txFrameSentOk(ev[3]), .rxBitValid(rxBitValid), .rxBit(rxBit),
        .rxLastRegFull(lv[3]), .rxLastFourFull(lv[4]), .rxEndMarker(lv[5]),
        .rxLastByteCount(cnt), .rxFrameGood(lv[6]), .rxCrcBad(lv[7]), .rxNonOctet(lv[8]),
        .rxOverrun(lv[9]), .rxClockUnstable(lv[10]), .dmaRxFrameWritten(ev[4]),
        .dmaRxNotOwned(ev[5]), .dmaTxNotOwned(ev[6]), .dmaTxFrameSent(ev[7]),
        .dpllMissedEdge(ev[8]), .dpllEdgeFound(ev[9]), .dmaTxEnable(dmaTxEnable),
        .dmaRxEnable(dmaRxEnable), .multiFrame(multiFrame), .dpllEnable(dpllEnable),
        .txAbortRequest(txAbortRequest), .dpllSearchRequest(dpllSearchRequest)
    );
    hsf_line_model farEnd (
        .mclk(mclk), .clear_to_send_n(clear_to_send_n), .carrier_detect_n(carrier_detect_n),
        .rxBitValid(rxBitValid), .rxBit(rxBit)
    );
    function automatic logic [31:0] rx_live(input logic [3:0] c, input logic [10:0] l,
        input logic f);
        rx_live = {8'h0, l[10], 3'h0, l[9:7], 2'h0, l[6], 4'h0, 1'b1, 5'h0,
            f ? c : {2'h0, c[1:0]}};
    endfunction : rx_live
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            errTotal++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        check({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic rdchk(input logic [31:0] m, input logic [31:0] v);
        apb(1'b0, ST, 32'h0);
        check(rd & hsf_pkg::STICKY_MASK, expSt);
        check(rd & m, v);
    endtask : rdchk
    task automatic wr1c(input logic [31:0] v);
        apb(1'b1, ST, v);
        expSt = expSt & ~v;
    endtask : wr1c
    task automatic pulse(input int i);
        @(posedge mclk);
        ev[i] <= 1'b1;
        @(posedge mclk);
        ev <= '0;
    endtask : pulse
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #100000;
        errTotal++;
        report_and_stop();
    end
    initial
    begin
        {sys_rst, clkEn} = 2'h3;
        {psel, penable, pwrite, paddr, pwdata, ev, lv, cnt, expSt} = '0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        rdchk(32'hFFFF_FFFF, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check({rd[30:0], err}, 32'h1);
        w = $random(seed);
        apb(1'b1, CT, w);
        apb(1'b0, CT, 32'h0);
        check(rd, w & hsf_pkg::CONTROL_MASK);
        apb(1'b1, CT, 32'h0);
        $display("test registers done");
        lv <= 11'h001;
        for (int i = 0; i < 6; i++)
        begin
            pulse(pi[i]);
            expSt[pb[i]] = 1'b1;
            rdchk(0, 0);
            wr1c($random(seed) & ~(32'h1 << pb[i]));
            rdchk(0, 0);
            wr1c(32'h1 << pb[i]);
            rdchk(0, 0);
        end
        $display("test events done");
        for (int p = 0; p < 2; p++)
        begin
            w = p ? 32'h1000 : 32'h40;
            farEnd.pin(p, 1'b0);
            repeat (3) @(posedge mclk);
            expSt = expSt | (w << 1);
            rdchk(w, w);
            wr1c(w << 1);
            rdchk(w, w);
            farEnd.pin(p, 1'b1);
            repeat (3) @(posedge mclk);
            expSt = expSt | (w << 1);
            rdchk(w, 0);
            wr1c(w << 1);
        end
        $display("test modem pins done");
        lv <= 11'h00B;
        apb(1'b1, CT, 32'h3);
        rdchk(32'h220, 0);
        pulse(2);
        expSt = expSt | 32'h0040_0100;
        rdchk(0, 0);
        apb(1'b0, CT, 32'h0);
        check(rd, 32'h2);
        wr1c(32'h0040_0100);
        apb(1'b1, CT, 32'h0);
        rdchk(32'h220, 32'h220);
        apb(1'b1, CT, 32'hC);
        rdchk(32'h220, 0);
        lv <= 11'h01F;
        rdchk(32'h220, 32'h220);
        for (int i = 0; i < 4; i++)
        begin
            cnt <= 4'($random(seed));
            lv <= {5'($random(seed)), 6'h20};
            apb(1'b1, CT, i[0] ? 32'h8 : 32'h0);
            rdchk(32'h008E_420F, rx_live(cnt, lv, i[0]));
        end
        lv <= '0;
        $display("test queues done");
        farEnd.send(8'h7E, 8, 0);
        expSt[11] = 1'b1;
        rdchk(0, 0);
        farEnd.send(8'hFF, 8, 1);
        expSt[16] = 1'b1;
        rdchk(0, 0);
        farEnd.send(8'hFF, 8, 0);
        wr1c(32'h8000);
        expSt[15] = 1'b1;
        rdchk(0, 0);
        farEnd.send(8'h00, 1, 0);
        wr1c(32'h0001_8800);
        rdchk(0, 0);
        $display("test line done");
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, CT, 32'((i[1] ? 8'h11 : 8'h01) << i[0]));
            pulse(i[0] ? 5 : 6);
            expSt[i[0] ? 26 : 29] = i[1];
            rdchk(0, 0);
            apb(1'b0, CT, 32'h0);
            if (i[1])
                check(rd & 32'h3, 32'h0);
            wr1c(32'h2400_0000);
        end
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, CT, i ? 32'h180 : 32'h80);
            pulse(8);
            pulse(8);
            expSt[31:30] = i ? 2'h3 : 2'h0;
            rdchk(0, 0);
            wr1c(32'hC000_0000);
        end
        apb(1'b1, CT, 32'h40);
        pulse(7);
        rdchk(0, 0);
        check({31'h0, multiFrame}, 32'h1);
        $display("test dma and dpll done");
        report_and_stop();
    end
endmodule : tb
